/* File: design/fcc_cfg.svh */
// Offsets, field positions, reset values and timing counts of the filter cascade control bank
`ifndef FCC_CFG_SVH
`define FCC_CFG_SVH
// Byte addresses on the host port
`define FCC_ADDR_LEN_LAST_LO 8'h80
`define FCC_ADDR_LEN_LAST_HI 8'h81
`define FCC_ADDR_LEN_SECOND_LO 8'h82
`define FCC_ADDR_LEN_SECOND_HI 8'h83
`define FCC_ADDR_LEN_FIRST_LO 8'h84
`define FCC_ADDR_LEN_FIRST_HI 8'h85
`define FCC_ADDR_STATIC 8'h90
`define FCC_ADDR_ACTIVE 8'h92
`define FCC_ADDR_BACKEND0 8'hA0
// Wishbone offsets of the controller's own registers (byte addresses, one 32-bit register every 4 bytes)
`define FCC_WB_CMD 4'h0
`define FCC_WB_WDATA 4'h4
`define FCC_WB_RDATA 4'h8
`define FCC_WB_STATUS 4'hC
// Field positions
`define FCC_LEN_MSB 10
`define FCC_LEN_MAX 11'h460
`define FCC_SC_POS_TABLE 6
`define FCC_SC_DELAY_OE 5
`define FCC_SC_CASC_OE 4
`define FCC_SC_UCOEF 3
`define FCC_SC_UDATA 2
`define FCC_SC_BYPASS 1
`define FCC_SC_SWAP 0
`define FCC_AC_TABLE_EN 1
`define FCC_AC_BANK 0
`define FCC_BC_FULL 7
`define FCC_BC_HALF 6
`define FCC_BC_ZERO_CASC 0
// Reserved-bit masks and reset values
`define FCC_MASK_STATIC 8'h7F
`define FCC_MASK_ACTIVE 8'h03
`define FCC_MASK_BACKEND0 8'hFF
`define FCC_RST_BYTE 8'h00
// Timing counts in cycles
`define FCC_LEN_SETTLE 22
`define FCC_BYPASS_DELAY 2
`define FCC_TABLE_WAIT 2
`define FCC_CFG_EFFECT_MAX 3
`endif

/* File: design/fcc_pkg.sv */
// Types shared by both ends of the filter cascade control bank
package fcc_pkg;
	typedef logic [7:0] fcc_byte_t;
	typedef logic [10:0] fcc_len_t;
	typedef enum logic [1:0] {
		FCC_RECT_THROUGH = 2'b00,
		FCC_RECT_HALF = 2'b01,
		FCC_RECT_FULL = 2'b10
	} fcc_rect_t;
endpackage : fcc_pkg

/* File: design/fcc_if.sv */
// Byte-wide host port between the controller and the register bank
`timescale 1ns/1ps
`default_nettype none
interface fcc_if;
	logic en;
	logic wr;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic rvalid;
	modport dev (input en, input wr, input addr, input wdata, output rdata, output rvalid);
	modport host (output en, output wr, output addr, output wdata, input rdata, input rvalid);
endinterface : fcc_if
`default_nettype wire

/* File: design/fcc_dev.sv */
// Register bank end of the filter cascade: control registers and the datapath controls they steer
`timescale 1ns/1ps
`default_nettype none
`include "fcc_cfg.svh"
// Function
// - Delay length equals low eleven bits, 0..1120; code does not clamp, up to 2047.
// - Last line output invalid 22 cycles after write.
// - Earlier line change ripples through later lines.
// - Reserved bits read zero; host writes zero; fcc_host masks static_config only.
// - Table address signed or unsigned by bit; table_addr_in_range_o is 1 in both settings.
// - Delay output pins tristate unless enabled.
// - Cascade output pins tristate unless enabled.
// - Unsigned-coefficient bit selects coefficient format.
// - Coefficient format captured per coefficient load.
// - Unsigned-data bit sets input format, static.
// - Bypass sends input to output in 2 cycles.
// - Continuous swap alternates banks every input cycle.
// - Table disabled: host owns it, output zero.
// - Host waits 2 cycles after table toggle.
// - Current bank bit picks bank zero or one.
// - Bank bit only seeds swap; host leaves it.
// - Full-wave takes absolute value, overrides half.
// - Half-wave zeroes negatives; else pass through.
// - Mac scaler two's complement, -8..+8 shifts.
// - Zero-cascade bit feeds zero to adder.
// - Config writes act within 0..3 cycles.
// - Length registers byte pairs, low byte first.
module fcc_dev #(
	parameter int DATA_W = 8,
	parameter int CASC_W = 22
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Host port
	fcc_if.dev bus,
	// Sample path
	input wire logic [DATA_W-1:0] delay_in_i,
	input wire logic [DATA_W-1:0] last_line_out_i,
	input wire logic [CASC_W-1:0] casc_sum_i,
	input wire logic [CASC_W-1:0] casc_in_i,
	input wire logic input_cycle_end_i,
	input wire logic coef_load_i,
	input wire logic [7:0] table_addr_i,
	input wire logic [7:0] table_data_i,
	// Datapath controls
	output logic [10:0] len_last_o,
	output logic [10:0] len_second_o,
	output logic [10:0] len_first_o,
	output logic len_settling_o,
	output logic [DATA_W-1:0] delay_out_o,
	output logic delay_out_oe_o,
	output logic [CASC_W-1:0] casc_feed_o,
	output logic [CASC_W-1:0] rect_out_o,
	output logic casc_out_oe_o,
	output logic coef_unsigned_o,
	output logic data_unsigned_o,
	output logic table_addr_in_range_o,
	output logic bank_o,
	output logic table_owned_o,
	output logic [7:0] table_out_o,
	output logic force_static_norm_o,
	output logic [4:0] mac_scale_o
);
	import fcc_pkg::*;

	fcc_byte_t static_r, active_r, backend_r;
	fcc_byte_t lo_last_r, lo_second_r, lo_first_r;
	fcc_len_t len_last_r, len_second_r, len_first_r;
	logic [4:0] settle_r;
	logic [DATA_W-1:0] byp0_r;
	logic bank_r;
	logic [1:0] tbl_pipe_r;
	fcc_rect_t rect_mode;
	logic wr_go;

	assign wr_go = bus.en && bus.wr;

	// ****************************************
	// Length registers
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lo_last_r <= `FCC_RST_BYTE;
			lo_second_r <= `FCC_RST_BYTE;
			lo_first_r <= `FCC_RST_BYTE;
			len_last_r <= '0;
			len_second_r <= '0;
			len_first_r <= '0;
		end else if (wr_go) begin
			unique case (bus.addr)
				`FCC_ADDR_LEN_LAST_LO: lo_last_r <= bus.wdata;
				`FCC_ADDR_LEN_SECOND_LO: lo_second_r <= bus.wdata;
				`FCC_ADDR_LEN_FIRST_LO: lo_first_r <= bus.wdata;
				`FCC_ADDR_LEN_LAST_HI: len_last_r <= {bus.wdata[2:0], lo_last_r};
				`FCC_ADDR_LEN_SECOND_HI: len_second_r <= {bus.wdata[2:0], lo_second_r};
				`FCC_ADDR_LEN_FIRST_HI: len_first_r <= {bus.wdata[2:0], lo_first_r};
				default: ;
			endcase
		end
	end

	// Settle window after the last line's length changes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			settle_r <= '0;
		end else if (wr_go && bus.addr == `FCC_ADDR_LEN_LAST_HI) begin
			settle_r <= 5'(`FCC_LEN_SETTLE);
		end else if (settle_r != '0) begin
			settle_r <= settle_r - 5'h01;
		end
	end

	// ****************************************
	// Control registers
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			static_r <= `FCC_RST_BYTE;
			active_r <= `FCC_RST_BYTE;
			backend_r <= `FCC_RST_BYTE;
		end else if (wr_go) begin
			unique case (bus.addr)
				`FCC_ADDR_STATIC: static_r <= bus.wdata & `FCC_MASK_STATIC;
				`FCC_ADDR_ACTIVE: active_r <= bus.wdata & `FCC_MASK_ACTIVE;
				`FCC_ADDR_BACKEND0: backend_r <= bus.wdata;
				default: ;
			endcase
		end
	end

	// ****************************************
	// Read port
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus.rdata <= '0;
			bus.rvalid <= 1'b0;
		end else begin
			bus.rvalid <= bus.en && !bus.wr;
			unique case (bus.addr)
				`FCC_ADDR_LEN_LAST_LO: bus.rdata <= len_last_r[7:0];
				`FCC_ADDR_LEN_LAST_HI: bus.rdata <= {5'h00, len_last_r[10:8]};
				`FCC_ADDR_LEN_SECOND_LO: bus.rdata <= len_second_r[7:0];
				`FCC_ADDR_LEN_SECOND_HI: bus.rdata <= {5'h00, len_second_r[10:8]};
				`FCC_ADDR_LEN_FIRST_LO: bus.rdata <= len_first_r[7:0];
				`FCC_ADDR_LEN_FIRST_HI: bus.rdata <= {5'h00, len_first_r[10:8]};
				`FCC_ADDR_STATIC: bus.rdata <= static_r;
				`FCC_ADDR_ACTIVE: bus.rdata <= active_r;
				`FCC_ADDR_BACKEND0: bus.rdata <= backend_r;
				default: bus.rdata <= 8'h00;
			endcase
		end
	end

	// ****************************************
	// Bank selection
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bank_r <= 1'b0;
		end else if (!static_r[`FCC_SC_SWAP]) begin
			bank_r <= active_r[`FCC_AC_BANK];
		end else if (wr_go && bus.addr == `FCC_ADDR_STATIC) begin
			bank_r <= active_r[`FCC_AC_BANK];
		end else if (input_cycle_end_i) begin
			bank_r <= !bank_r;
		end
	end

	// ****************************************
	// Datapath controls
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			byp0_r <= '0;
			delay_out_o <= '0;
		end else begin
			byp0_r <= delay_in_i;
			delay_out_o <= static_r[`FCC_SC_BYPASS] ? byp0_r : last_line_out_i;
		end
	end

	always_comb begin
		rect_mode = FCC_RECT_THROUGH;
		if (backend_r[`FCC_BC_FULL])
			rect_mode = FCC_RECT_FULL;
		else if (backend_r[`FCC_BC_HALF])
			rect_mode = FCC_RECT_HALF;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rect_out_o <= '0;
			casc_feed_o <= '0;
			coef_unsigned_o <= 1'b0;
			tbl_pipe_r <= '0;
			table_out_o <= '0;
			table_addr_in_range_o <= 1'b0;
		end else begin
			unique case (rect_mode)
				FCC_RECT_FULL: rect_out_o <= casc_sum_i[CASC_W-1] ? -casc_sum_i : casc_sum_i;
				FCC_RECT_HALF: rect_out_o <= casc_sum_i[CASC_W-1] ? '0 : casc_sum_i;
				default: rect_out_o <= casc_sum_i;
			endcase
			casc_feed_o <= backend_r[`FCC_BC_ZERO_CASC] ? '0 : casc_in_i;
			if (coef_load_i)
				coef_unsigned_o <= static_r[`FCC_SC_UCOEF];
			tbl_pipe_r <= {tbl_pipe_r[0], active_r[`FCC_AC_TABLE_EN]};
			table_out_o <= active_r[`FCC_AC_TABLE_EN] ? table_data_i : 8'h00;
			table_addr_in_range_o <= static_r[`FCC_SC_POS_TABLE] ? 1'b1 :
				(table_addr_i <= 8'h7F || table_addr_i >= 8'h80);
		end
	end

	// Register copies; most act one cycle after the register write, bank_o two and table_owned_o three, within the 0..3 window
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			len_last_o <= '0;
			len_second_o <= '0;
			len_first_o <= '0;
			len_settling_o <= 1'b0;
			delay_out_oe_o <= 1'b0;
			casc_out_oe_o <= 1'b0;
			data_unsigned_o <= 1'b0;
			bank_o <= 1'b0;
			table_owned_o <= 1'b0;
			force_static_norm_o <= 1'b1;
			mac_scale_o <= '0;
		end else begin
			len_last_o <= len_last_r;
			len_second_o <= len_second_r;
			len_first_o <= len_first_r;
			len_settling_o <= settle_r != '0;
			delay_out_oe_o <= static_r[`FCC_SC_DELAY_OE];
			casc_out_oe_o <= static_r[`FCC_SC_CASC_OE];
			data_unsigned_o <= static_r[`FCC_SC_UDATA];
			bank_o <= bank_r;
			table_owned_o <= tbl_pipe_r[1];
			force_static_norm_o <= !active_r[`FCC_AC_TABLE_EN];
			mac_scale_o <= backend_r[5:1];
		end
	end
endmodule : fcc_dev
`default_nettype wire

/* File: design/fcc_host.sv */
// Controller end: takes byte orders over Wishbone and runs them on the byte-wide host port
`timescale 1ns/1ps
`default_nettype none
`include "fcc_cfg.svh"
module fcc_host (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Byte port to the bank
	fcc_if.host bus
);
	import fcc_pkg::*;

	typedef enum logic [1:0] {
		FCC_H_IDLE = 2'b00,
		FCC_H_ACCESS = 2'b01,
		FCC_H_WAIT = 2'b10
	} fcc_hstate_t;

	fcc_hstate_t state_r;
	fcc_byte_t wdata_r, rdata_r;
	logic [1:0] gap_r;
	logic busy;

	assign busy = state_r != FCC_H_IDLE || gap_r != '0;

	// ****************************************
	// Wishbone slave
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= '0;
		end else begin
			ack_o <= cyc_i && stb_i && !ack_o;
			unique case (adr_i)
				`FCC_WB_WDATA: dat_o <= {24'h000000, wdata_r};
				`FCC_WB_RDATA: dat_o <= {24'h000000, rdata_r};
				`FCC_WB_STATUS: dat_o <= {31'h00000000, busy};
				default: dat_o <= 32'h00000000;
			endcase
		end
	end

	// ****************************************
	// Port sequencer
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= FCC_H_IDLE;
			wdata_r <= '0;
			rdata_r <= '0;
			gap_r <= '0;
			bus.en <= 1'b0;
			bus.wr <= 1'b0;
			bus.addr <= '0;
			bus.wdata <= '0;
		end else begin
			if (gap_r != '0)
				gap_r <= gap_r - 2'h1;
			unique case (state_r)
				FCC_H_IDLE: begin
					if (cyc_i && stb_i && we_i && !ack_o && sel_i[0]) begin
						if (adr_i == `FCC_WB_WDATA)
							wdata_r <= dat_i[7:0] & ((dat_i[15:8] == `FCC_ADDR_STATIC) ?
								`FCC_MASK_STATIC : 8'hFF);
						if (adr_i == `FCC_WB_CMD && gap_r == '0) begin
							bus.en <= 1'b1;
							bus.wr <= dat_i[8];
							bus.addr <= dat_i[7:0];
							bus.wdata <= wdata_r;
							state_r <= FCC_H_ACCESS;
						end
					end
				end
				FCC_H_ACCESS: begin
					bus.en <= 1'b0;
					state_r <= bus.wr ? FCC_H_IDLE : FCC_H_WAIT;
					if (bus.wr && bus.addr == `FCC_ADDR_ACTIVE)
						gap_r <= 2'(`FCC_TABLE_WAIT);
				end
				FCC_H_WAIT: begin
					if (bus.rvalid) begin
						rdata_r <= bus.rdata;
						state_r <= FCC_H_IDLE;
					end
				end
				default: state_r <= FCC_H_IDLE;
			endcase
		end
	end
endmodule : fcc_host
`default_nettype wire

/* File: verif/fcc_assertions.sv */
// Concurrent checks on the byte port between controller and bank
`timescale 1ns/1ps
`default_nettype none
module fcc_assertions (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Byte port
	input wire logic en,
	input wire logic wr,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic rvalid
);
	// ****************
	// Shadow of static_config
	// ****************
	logic [7:0] static_r;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			static_r <= 8'h00;
		end else if (en && wr && addr == 8'h90) begin
			static_r <= wdata;
		end
	end
	a_read_gets_answer: assert property (en && !wr |=> rvalid) else $error("read without answer");
	a_answer_has_cause: assert property (rvalid |-> $past(en && !wr)) else $error("stray read answer");
	a_strobe_single: assert property (en |=> !en) else $error("strobe too long");
	a_table_gap_kept: assert property (en && wr && addr == 8'h92 |=> !en [*2]) else $error("table gap short");
	a_len_hi_zero: assert property (rvalid && $past(addr) inside {8'h81, 8'h83, 8'h85} |-> rdata[7:3] == 5'h00)
		else $error("length reserved bits set");
	a_active_zero: assert property (rvalid && $past(addr) == 8'h92 |-> rdata[7:2] == 6'h00)
		else $error("active reserved bits set");
	a_static_back: assert property (rvalid && $past(addr) == 8'h90 |-> rdata == (static_r & 8'h7F))
		else $error("static readback wrong");
	a_unmapped_zero: assert property (rvalid && !($past(addr) inside {[8'h80:8'h85], 8'h90, 8'h92, 8'hA0})
		|-> rdata == 8'h00) else $error("unmapped read not zero");
	cover property (en && wr && addr == 8'h81);
	cover property (rvalid && $past(addr) == 8'h90);
	cover property (en && wr && addr == 8'h92);
endmodule : fcc_assertions
`default_nettype wire

/* File: verif/filter_cascade_control_regs_test.sv */
// Self-checking bench driving both ends of the filter cascade control bank
`timescale 1ns/1ps
`default_nettype none
`include "fcc_cfg.svh"
module filter_cascade_control_regs_test;
	import fcc_pkg::*;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ice = 0, cld = 0;
	logic [3:0] adr = 0;
	logic [31:0] wdat = 0, rdat, rd;
	logic ack, settle, doe, coe, cu, du, rng, bank, own, fsn;
	logic [7:0] din = 0, tadr = 0, tdat = 8'h3C, dout, tout;
	logic [21:0] csum = 22'h3FFFFB, cin = 22'h00ABCD, feed, rect;
	logic [10:0] ll, ls, lf;
	logic [4:0] scl;
	logic [7:0] ra[10] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h90, 8'h92, 8'hA0, 8'hA5};
	logic [7:0] bv[5] = '{8'h80, 8'hC0, 8'h40, 8'h10, 8'h31};
	logic [21:0] re[5] = '{22'h5, 22'h5, 22'h0, 22'h3FFFFB, 22'h3FFFFB};
	logic [21:0] fe[5] = '{22'hABCD, 22'hABCD, 22'hABCD, 22'hABCD, 22'h0};
	logic [4:0] sc[5] = '{5'h00, 5'h00, 5'h00, 5'h08, 5'h18};
	int n_mismatch = 0, compares = 0;
	fcc_if fcc_if_i();
	fcc_host fcc_host_i(.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
		.sel_i(4'hF), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .bus(fcc_if_i.host));
	fcc_dev fcc_dev_i(.clk_i(clk_i), .rst_i(rst_i), .bus(fcc_if_i.dev), .delay_in_i(din), .last_line_out_i(8'hC3),
		.casc_sum_i(csum), .casc_in_i(cin), .input_cycle_end_i(ice), .coef_load_i(cld), .table_addr_i(tadr),
		.table_data_i(tdat), .len_last_o(ll), .len_second_o(ls), .len_first_o(lf), .len_settling_o(settle),
		.delay_out_o(dout), .delay_out_oe_o(doe), .casc_feed_o(feed), .rect_out_o(rect), .casc_out_oe_o(coe),
		.coef_unsigned_o(cu), .data_unsigned_o(du), .table_addr_in_range_o(rng), .bank_o(bank),
		.table_owned_o(own), .table_out_o(tout), .force_static_norm_o(fsn), .mac_scale_o(scl));
	fcc_assertions fcc_assertions_i(.clk_i(clk_i), .rst_i(rst_i), .en(fcc_if_i.en), .wr(fcc_if_i.wr),
		.addr(fcc_if_i.addr), .wdata(fcc_if_i.wdata), .rdata(fcc_if_i.rdata), .rvalid(fcc_if_i.rvalid));
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	// ****************
	// Access and compare tasks
	// ****************
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
		end
	endtask : chk
	task automatic hang();
		n_mismatch++;
		$display("[FAIL] %0t wait ran out", $time);
		report_and_stop();
	endtask : hang
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int k;
		k = 0;
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack !== 1'b1 && k < 50);
		if (ack !== 1'b1) hang();
		rd = rdat;
		cyc <= 0;
		stb <= 0;
		@(posedge clk_i);
	endtask : wb
	task automatic idle();
		for (int k = 0; k < 40; k++) begin
			wb(0, `FCC_WB_STATUS, 0);
			if (rd[0] === 1'b0) return;
		end
		hang();
	endtask : idle
	task automatic bw(input logic [7:0] a, input logic [7:0] d);
		idle();
		wb(1, `FCC_WB_WDATA, {16'h0, a, d});
		wb(1, `FCC_WB_CMD, {23'h0, 1'b1, a});
		idle();
	endtask : bw
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		idle();
		wb(1, `FCC_WB_CMD, {24'h0, a});
		idle();
		wb(0, `FCC_WB_RDATA, 0);
		chk(rd[7:0], exp);
	endtask : rd_chk
	task automatic pulse(input logic sel_ice);
		if (sel_ice) begin
			ice <= 1;
		end else begin
			cld <= 1;
		end
		@(posedge clk_i);
		ice <= 0;
		cld <= 0;
		repeat (3) @(posedge clk_i);
	endtask : pulse
	// ****************
	// Main sequence
	// ****************
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		foreach (ra[i]) rd_chk(ra[i], 8'h00);
		chk({doe, coe, fsn, own, tout}, 12'h200);
		bw(8'h80, 8'h60);
		chk(ll, 11'h000);
		bw(8'h81, 8'h04);
		chk({settle, ll}, 12'hC60);
		rd_chk(8'h81, 8'h04);
		bw(8'h82, 8'h01);
		bw(8'h83, 8'h02);
		bw(8'h84, 8'hFF);
		bw(8'h85, 8'h03);
		chk({ls, lf}, {11'h201, 11'h3FF});
		repeat (30) @(posedge clk_i);
		chk(settle, 0);
		bw(8'h90, 8'h36);
		repeat (4) @(posedge clk_i);
		chk({doe, coe, du}, 3'b111);
		din <= 8'h5A;
		repeat (2) @(posedge clk_i);
		chk(dout, 8'h00);
		@(posedge clk_i);
		chk(dout, 8'h5A);
		bw(8'h90, 8'h78);
		repeat (4) @(posedge clk_i);
		chk({dout, du, rng}, 10'h30D);
		pulse(1'b0);
		chk(cu, 1);
		bw(8'h90, 8'h30);
		chk(cu, 1);
		pulse(1'b0);
		chk(cu, 0);
		for (int i = 0; i < 5; i++) begin
			bw(8'hA0, bv[i]);
			repeat (4) @(posedge clk_i);
			chk(rect, re[i]);
			chk({feed, scl}, {fe[i], sc[i]});
		end
		bw(8'h92, 8'h01);
		repeat (4) @(posedge clk_i);
		chk(bank, 1);
		bw(8'h92, 8'h02);
		repeat (5) @(posedge clk_i);
		chk({bank, own, fsn, tout}, 11'h23C);
		rd_chk(8'h92, 8'h02);
		bw(8'h92, 8'h00);
		repeat (5) @(posedge clk_i);
		chk({own, fsn, tout}, 10'h100);
		bw(8'h90, 8'h31);
		repeat (4) @(posedge clk_i);
		chk(bank, 0);
		pulse(1'b1);
		chk(bank, 1);
		pulse(1'b1);
		chk(bank, 0);
		report_and_stop();
	end
endmodule : filter_cascade_control_regs_test
`default_nettype wire
